//--- src/ccsr_pkg.sv
// package for the common command status and reset block
// assumes one 40 MHz clock; commands arrive already parsed as codes
package ccsr_pkg;
	// command codes from the parser
	typedef enum logic [3:0] {
		CMD_NONE = 4'h0, CMD_CLEAR = 4'h1, CMD_EVT_EN = 4'h2, CMD_EVT_EN_Q = 4'h3,
		CMD_EVT_Q = 4'h4, CMD_MAC_EN = 4'h5, CMD_MAC_EN_Q = 4'h6, CMD_OPC = 4'h7,
		CMD_OPC_Q = 4'h8, CMD_PURGE = 4'h9, CMD_REMOVE = 4'ha, CMD_DEFINE = 4'hb,
		CMD_RESET = 4'hc, CMD_IDN_Q = 4'hd, CMD_GET_MAC_Q = 4'he, CMD_LIST_MAC_Q = 4'hf
	} ccsr_cmd_t;
	typedef struct packed {
		logic        valid;
		ccsr_cmd_t   code;
		logic [15:0] arg;   // mask, enable flag or macro slot
	} ccsr_req_t;
	typedef struct packed {
		logic        valid;
		logic [15:0] data;
	} ccsr_rsp_t;
	// event bit positions
	localparam int EV_OPC = 0;
	localparam int EV_PON = 7;
	// status byte summary positions
	localparam int SB_QUES = 3;
	localparam int SB_EVT  = 5;
	localparam int SB_OPER = 7;
	localparam int QUES_RST_BIT = 13;
	localparam int MAC_SLOTS = 8;
	localparam int MAC_IDX_W = 3;
	// reset timing
	localparam int CLK_HZ        = 40_000_000;
	localparam int OUT_DIS_US    = 5000;  // least disconnect time
	localparam int OUT_DIS_CYC   = (OUT_DIS_US * (CLK_HZ / 1_000_000));
	localparam int TRIG_PER_US   = 10000; // 10e-3 s
	localparam int SAMP_PER_NS   = 40000; // 40e-6 s
	localparam logic [15:0] OPC_ONE = 16'h0001;
	localparam logic [15:0] EMPTY   = 16'h0000;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001, ST_DISCH = 3'b010, ST_DONE = 3'b100
	} ccsr_st_t;
	typedef struct packed {
		ccsr_st_t              st;
		logic [7:0]            evt;
		logic [7:0]            ena;
		logic                  mac_en;
		logic                  opc_arm;
		logic                  opcq_arm;
		logic [MAC_SLOTS-1:0]  mac_def;
		logic [31:0]           cnt;
		logic                  ques13;
		logic                  err_clr;
		ccsr_rsp_t             rsp;
	} ccsr_state_t;
endpackage

//--- src/ccsr_top.sv
// common command status and reset block
// assumes a parser delivering one request per cycle and a host reading responses
//
// Functional notes
// - clear status clears standard, operation, questionable events and error queue; here only standard events and the error queue (ERRQ_CLEAR) are cleared.
// - clear status also clears status byte summary bits 3, 5, 7; here bits 3 and 7 are held low only in the clear request cycle.
// - clear status keeps every enable mask.
// - clear status cancels armed operation-complete set and query.
// - macro may shadow a SCPI command name while macros are enabled.
// - macro enable nonzero enables, zero disables; query reports 1 or 0.
// - event enable mask selects event bits feeding status byte bit 5.
// - enable query returns current mask.
// - event query returns set bits then clears the register.
// - event bits latch regardless of mask.
// - get-macro returns stored sequence; list returns names or empty; here get gives the slot's defined flag, list a mask of defined slots.
// - identity gives maker, model, serial, revision; unknowns read 0; here the answer is serial OR revision, both 0.
// - after complete command, bit 0 set once pending operations finish.
// - complete query answers 1 only when nothing pending.
// - purge deletes all macros; remove deletes the named one.
// - reset erases algorithms, zeroes buffers, sets default channel modes.
// - reset selects timer trigger 10 ms, unlimited count, immediate arm, 40 us sample.
// - reset aborts operations, goes trigger idle, cancels complete modes.
// - reset sets questionable condition bit 13.
// - reset keeps calibration, output queue, service and event enables.
// - reset refused while initiated; outputs disconnect 5 to 6 ms; here 5 ms, and a reset taken in ST_DISCH or ST_DONE does not restart it.
`timescale 1ns/1ps
module ccsr_top
	import ccsr_pkg::*;
(
	// clock and reset
	input  wire logic        SYS_CLK,
	input  wire logic        RSTN,
	// parsed requests and answers
	input  wire ccsr_req_t   REQ,
	output ccsr_rsp_t        RSP,
	// device events and state
	input  wire logic [7:1]  EVT_IN,
	input  wire logic        PENDING,
	input  wire logic        INITIATED,
	input  wire logic        OPER_SUM,
	input  wire logic        QUES_SUM,
	input  wire logic        SCPI_HIT,
	// status and reset actions
	output logic [7:0]       STATUS_SUM,
	output logic             ERRQ_CLEAR,
	output logic             MAC_RUN,
	output logic [MAC_IDX_W-1:0] MAC_DEL_IDX,
	output logic             DEV_RESET,
	output logic             OUT_DISCONNECT,
	output logic             QUES_BIT13,
	output logic             RST_REFUSED
);
	// ----------------------------------------
	// state
	// ----------------------------------------
	ccsr_state_t s_r, s_nxt;
	logic        is_clr, is_rst;
	logic        opc_fire;
	logic [15:0] idn_serial, idn_rev;

	// unavailable identity fields read zero
	assign idn_serial = EMPTY;
	assign idn_rev    = EMPTY;
	assign is_clr = REQ.valid && REQ.code == CMD_CLEAR;
	// armed completion lands once nothing is pending
	assign opc_fire = s_r.opc_arm && !PENDING;
	assign is_rst = REQ.valid && REQ.code == CMD_RESET && !INITIATED;

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		s_nxt = s_r;
		s_nxt.rsp = '{valid: 1'b0, data: EMPTY};
		s_nxt.err_clr = 1'b0;
		// events latch regardless of mask
		s_nxt.evt[7:1] = s_r.evt[7:1] | EVT_IN;
		if (opc_fire) begin
			s_nxt.evt[EV_OPC] = 1'b1;
			s_nxt.opc_arm = 1'b0;
		end
		if (s_r.opcq_arm && !PENDING) begin
			s_nxt.rsp = '{valid: 1'b1, data: OPC_ONE};
			s_nxt.opcq_arm = 1'b0;
		end
		if (REQ.valid) begin
			case (REQ.code)
				CMD_CLEAR: begin
					// same-cycle device events still land, set wins
					s_nxt.evt = {EVT_IN, 1'b0}; // enables untouched
					s_nxt.err_clr = 1'b1;
					s_nxt.opc_arm = 1'b0;
					s_nxt.opcq_arm = 1'b0;
				end
				CMD_EVT_EN: s_nxt.ena = REQ.arg[7:0];
				CMD_EVT_EN_Q: s_nxt.rsp = '{valid: 1'b1, data: {8'h00, s_r.ena}};
				CMD_EVT_Q: begin
					s_nxt.rsp = '{valid: 1'b1, data: {8'h00, s_r.evt}};
					// new events and a landing completion survive the read
					s_nxt.evt = {EVT_IN, opc_fire};
				end
				CMD_MAC_EN: s_nxt.mac_en = |REQ.arg;
				CMD_MAC_EN_Q: s_nxt.rsp = '{valid: 1'b1, data: {15'h0000, s_r.mac_en}};
				CMD_OPC: s_nxt.opc_arm = 1'b1;
				CMD_OPC_Q: s_nxt.opcq_arm = 1'b1;
				CMD_DEFINE: s_nxt.mac_def[REQ.arg[MAC_IDX_W-1:0]] = 1'b1;
				CMD_PURGE: s_nxt.mac_def = '0;
				CMD_REMOVE: s_nxt.mac_def[REQ.arg[MAC_IDX_W-1:0]] = 1'b0;
				CMD_GET_MAC_Q: s_nxt.rsp = '{valid: 1'b1,
					data: {15'h0000, s_r.mac_def[REQ.arg[MAC_IDX_W-1:0]]}};
				CMD_LIST_MAC_Q: s_nxt.rsp = '{valid: 1'b1,
					data: {8'h00, s_r.mac_def}}; // zero means empty list
				CMD_IDN_Q: s_nxt.rsp = '{valid: 1'b1, data: idn_serial | idn_rev};
				CMD_RESET: begin
					if (!INITIATED) begin
						// abort, trigger idle, cancel complete modes
						s_nxt.opc_arm = 1'b0;
						s_nxt.opcq_arm = 1'b0;
						s_nxt.ques13 = 1'b1;
						s_nxt.st = ST_DISCH;
						s_nxt.cnt = '0;
					end
				end
				default: ;
			endcase
		end
		// reset output discharge timer
		case (s_r.st)
			ST_IDLE: ;
			ST_DISCH: begin
				s_nxt.cnt = s_r.cnt + 32'h0000_0001;
				if (s_r.cnt == 32'(OUT_DIS_CYC - 1))
					s_nxt.st = ST_DONE;
			end
			ST_DONE: s_nxt.st = ST_IDLE;
			default: s_nxt.st = ST_IDLE;
		endcase
		if (is_clr)
			s_nxt.ques13 = s_r.ques13;
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			s_r <= '{st: ST_IDLE, evt: 8'h80, ena: 8'h00, mac_en: 1'b0,
				opc_arm: 1'b0, opcq_arm: 1'b0, mac_def: '0, cnt: '0,
				ques13: 1'b0, err_clr: 1'b0, rsp: '{valid: 1'b0, data: 16'h0000}};
		end else begin
			s_r <= s_nxt;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	always_comb begin
		STATUS_SUM = '0;
		STATUS_SUM[SB_QUES] = QUES_SUM && !is_clr;
		STATUS_SUM[SB_EVT]  = |(s_r.evt & s_r.ena);
		STATUS_SUM[SB_OPER] = OPER_SUM && !is_clr;
	end
	assign RSP            = s_r.rsp;
	assign ERRQ_CLEAR     = s_r.err_clr;
	assign MAC_RUN        = s_r.mac_en && SCPI_HIT;
	assign MAC_DEL_IDX    = REQ.arg[MAC_IDX_W-1:0];
	assign DEV_RESET      = is_rst;
	assign OUT_DISCONNECT = s_r.st == ST_DISCH;
	assign QUES_BIT13     = s_r.ques13;
	assign RST_REFUSED    = REQ.valid && REQ.code == CMD_RESET && INITIATED;
endmodule

//--- verification/ccsr_sva.sv
// checker for the common command status and reset block
// assumes parsed requests on REQ and one clock domain
`timescale 1ns/1ps
module ccsr_sva
	import ccsr_pkg::*;
(
	// clock, reset and requests
	input wire logic      SYS_CLK, RSTN, PENDING, INITIATED, SCPI_HIT,
	input wire ccsr_req_t REQ,
	input wire logic [7:1] EVT_IN,
	// answers and actions
	input wire ccsr_rsp_t RSP,
	input wire logic [7:0] STATUS_SUM,
	input wire logic [MAC_IDX_W-1:0] MAC_DEL_IDX,
	input wire logic      ERRQ_CLEAR, MAC_RUN, DEV_RESET, OUT_DISCONNECT, QUES_BIT13, RST_REFUSED
);
	// -----------------------------
	// taken command
	// -----------------------------
	ccsr_cmd_t c;
	assign c = REQ.valid ? REQ.code : CMD_NONE;
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (!RSTN);
	a_clr_errq: assert property (c == CMD_CLEAR |=> ERRQ_CLEAR)
		else $error("error queue not cleared");
	a_clr_sum: assert property (c == CMD_CLEAR && EVT_IN == 0 |->
		!STATUS_SUM[3] && !STATUS_SUM[7] ##1 !STATUS_SUM[5]) else $error("summary kept");
	a_mac_off: assert property (!SCPI_HIT |-> !MAC_RUN)
		else $error("macro run without match");
	a_opcq_hold: assert property (c == CMD_OPC_Q && PENDING |=> !RSP.valid)
		else $error("early completion answer");
	a_idn_zero: assert property (c == CMD_IDN_Q |=> RSP.valid && RSP.data == 0)
		else $error("bad identity answer");
	a_evt_clr: assert property (c == CMD_EVT_Q && EVT_IN == 0 && PENDING |=> !STATUS_SUM[5])
		else $error("event bits not cleared");
	a_del_idx: assert property (c == CMD_REMOVE |-> MAC_DEL_IDX == REQ.arg[MAC_IDX_W-1:0])
		else $error("wrong macro slot removed");
	a_rst_refuse: assert property (c == CMD_RESET && INITIATED |-> RST_REFUSED && !DEV_RESET)
		else $error("reset not refused");
	a_rst_go: assert property (c == CMD_RESET && !INITIATED |->
		DEV_RESET ##1 QUES_BIT13 && OUT_DISCONNECT) else $error("reset not applied");
	cover property (c == CMD_CLEAR);
	cover property (DEV_RESET);
	cover property (RST_REFUSED);
	cover property (RSP.valid && RSP.data == OPC_ONE);
endmodule
bind ccsr_top ccsr_sva u_sva (.*);

//--- verification/ccsr_host.sv
// host model issuing parsed common commands
// assumes registered answers on rsp
`timescale 1ns/1ps
module ccsr_host
	import ccsr_pkg::*;
(
	// request and answer
	input  wire logic      clk,
	input  wire ccsr_rsp_t rsp,
	output ccsr_req_t      req
);
	initial req = '0;
	// one-cycle command pulse, mask as sum of weights
	task automatic send(input ccsr_cmd_t c, input logic [15:0] a);
		@(posedge clk);
		req <= '{1'b1, c, a};
		@(posedge clk);
		req <= '0;
	endtask
	// bounded wait for an answer, unknown if none
	task automatic get(input int n, output logic [15:0] d);
		d = 'x;
		repeat (n) begin
			#1;
			if (rsp.valid) begin
				d = rsp.data;
				return;
			end
			@(posedge clk);
		end
	endtask
endmodule

//--- verification/common_command_status_reset_test.sv
// testbench for the common command status and reset block
// assumes the host model and the bound checker
`timescale 1ns/1ps
module common_command_status_reset_test;
	import ccsr_pkg::*;
	logic SYS_CLK = 0, RSTN = 0, PENDING = 0, INITIATED = 0, SCPI_HIT = 0;
	logic OPER_SUM = 0, QUES_SUM = 0, ERRQ_CLEAR, MAC_RUN, DEV_RESET;
	logic OUT_DISCONNECT, QUES_BIT13, RST_REFUSED;
	logic [7:1] EVT_IN = '0;
	logic [7:0] STATUS_SUM;
	logic [2:0] MAC_DEL_IDX;
	logic [15:0] d;
	ccsr_req_t REQ;
	ccsr_rsp_t RSP;
	int n_errors = 0, n_compared = 0;
	always #12.5 SYS_CLK = ~SYS_CLK;
	ccsr_host u_host (.clk(SYS_CLK), .rsp(RSP), .req(REQ));
	ccsr_top u_dut (
		.SYS_CLK(SYS_CLK), .RSTN(RSTN), .REQ(REQ), .RSP(RSP), .EVT_IN(EVT_IN),
		.PENDING(PENDING), .INITIATED(INITIATED), .OPER_SUM(OPER_SUM),
		.QUES_SUM(QUES_SUM), .SCPI_HIT(SCPI_HIT), .STATUS_SUM(STATUS_SUM),
		.ERRQ_CLEAR(ERRQ_CLEAR), .MAC_RUN(MAC_RUN), .MAC_DEL_IDX(MAC_DEL_IDX),
		.DEV_RESET(DEV_RESET), .OUT_DISCONNECT(OUT_DISCONNECT),
		.QUES_BIT13(QUES_BIT13), .RST_REFUSED(RST_REFUSED));
	task chk(input logic [15:0] s, e, input string nm);
		n_compared++;
		if (s !== e) begin
			n_errors++;
			$display("unexpected %s: expected %h, seen %h", nm, e, s);
		end
	endtask
	task q(input ccsr_cmd_t c, input logic [15:0] a, e, input string nm);
		u_host.send(c, a);
		u_host.get(4, d);
		chk(d, e, nm);
	endtask
	task pulse(input logic [7:1] v);
		@(posedge SYS_CLK) EVT_IN <= v;
		@(posedge SYS_CLK) EVT_IN <= '0;
		#1;
	endtask
	task close_out;
		if (n_errors == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// -----------------------------
	// scenarios
	// -----------------------------
	initial begin
		repeat (12) @(posedge SYS_CLK);
		RSTN <= 1;
		q(CMD_EVT_Q, 0, 16'h0080, "power-on event");
		q(CMD_EVT_Q, 0, 16'h0000, "cleared events");
		u_host.send(CMD_EVT_EN, 16'hff81);
		q(CMD_EVT_EN_Q, 0, 16'h0081, "event enable");
		pulse(7'h02);
		chk(STATUS_SUM[5], 0, "masked summary");
		pulse(7'h40);
		chk(STATUS_SUM[5], 1, "enabled summary");
		q(CMD_EVT_Q, 0, 16'h0084, "latched events");
		// clear with completion armed and other summaries high
		pulse(7'h40);
		@(posedge SYS_CLK) PENDING <= 1;
		OPER_SUM <= 1;
		QUES_SUM <= 1;
		u_host.send(CMD_OPC, 0);
		u_host.send(CMD_CLEAR, 0);
		#1;
		chk(ERRQ_CLEAR, 1, "error queue clear");
		chk(STATUS_SUM[5], 0, "summary after clear");
		@(posedge SYS_CLK) PENDING <= 0;
		repeat (3) @(posedge SYS_CLK);
		q(CMD_EVT_Q, 0, 16'h0000, "completion cancelled");
		q(CMD_EVT_EN_Q, 0, 16'h0081, "mask after clear");
		// completion flag and query
		@(posedge SYS_CLK) PENDING <= 1;
		u_host.send(CMD_OPC, 0);
		q(CMD_EVT_Q, 0, 16'h0000, "completion while busy");
		@(posedge SYS_CLK) PENDING <= 0;
		repeat (2) @(posedge SYS_CLK);
		q(CMD_EVT_Q, 0, 16'h0001, "completion set");
		@(posedge SYS_CLK) PENDING <= 1;
		q(CMD_OPC_Q, 0, 16'hxxxx, "query while busy");
		@(posedge SYS_CLK) PENDING <= 0;
		u_host.get(4, d);
		chk(d, 16'h0001, "completion answer");
		// macro enable and store
		u_host.send(CMD_MAC_EN, 16'h0005);
		q(CMD_MAC_EN_Q, 0, 16'h0001, "macros on");
		@(posedge SYS_CLK) SCPI_HIT <= 1;
		#1;
		chk(MAC_RUN, 1, "macro shadows command");
		u_host.send(CMD_MAC_EN, 0);
		q(CMD_MAC_EN_Q, 0, 16'h0000, "macros off");
		chk(MAC_RUN, 0, "command regained");
		u_host.send(CMD_DEFINE, 16'h0003);
		u_host.send(CMD_DEFINE, 16'h0005);
		q(CMD_LIST_MAC_Q, 0, 16'h0028, "macro list");
		q(CMD_GET_MAC_Q, 16'h0005, 16'h0001, "macro get");
		u_host.send(CMD_REMOVE, 16'h0003);
		q(CMD_LIST_MAC_Q, 0, 16'h0020, "list after remove");
		u_host.send(CMD_PURGE, 0);
		q(CMD_LIST_MAC_Q, 0, 16'h0000, "list after purge");
		q(CMD_IDN_Q, 0, 16'h0000, "identity");
		// reset refused, then accepted with completion armed
		@(posedge SYS_CLK) INITIATED <= 1;
		u_host.send(CMD_RESET, 0);
		#1;
		chk(OUT_DISCONNECT, 0, "refused reset");
		@(posedge SYS_CLK) INITIATED <= 0;
		PENDING <= 1;
		u_host.send(CMD_OPC, 0);
		u_host.send(CMD_RESET, 0);
		@(posedge SYS_CLK) PENDING <= 0;
		repeat (3) @(posedge SYS_CLK);
		q(CMD_EVT_Q, 0, 16'h0000, "completion after reset");
		q(CMD_EVT_EN_Q, 0, 16'h0081, "mask after reset");
		chk(QUES_BIT13, 1, "questionable bit");
		chk(OUT_DISCONNECT, 1, "outputs disconnected");
		close_out;
	end
	// watchdog
	initial begin
		repeat (3000) @(posedge SYS_CLK);
		n_errors++;
		close_out;
	end
endmodule
